// [hw/rxqw_cfg.svh]
// Offsets, field positions, reset values and constants for the receive-queue water marks
`ifndef RXQW_CFG_SVH
`define RXQW_CFG_SVH
`define RXQW_ADDR_W          11
`define RXQW_OFF_LOW         11'h1B0
`define RXQW_OFF_HIGH        11'h1B2
`define RXQW_OFF_OVERRUN     11'h1B4
`define RXQW_OFF_TALLY       11'h1B8
`define RXQW_MARK_W          12
`define RXQW_MARK_MSB        11
`define RXQW_RSV_MSB         15
`define RXQW_RSV_LSB         12
`define RXQW_LOW_RST         12'h600
`define RXQW_HIGH_RST        12'h400
`define RXQW_OVERRUN_RST     12'h040
`define RXQW_TALLY_MSB       15
`define RXQW_TALLY_LSB       8
`define RXQW_TALLY_W         8
`define RXQW_TALLY_RST       8'h00
`define RXQW_TALLY_LOW_RST   8'h00
`define RXQW_ISR_RX_BIT      13
`define RXQW_SPACE_W         12
`endif

// [hw/rxqw_flow.sv]
// Flow-control state machine comparing free receive-queue space with the water marks
`timescale 1ns/1ps
`include "rxqw_cfg.svh"
module rxqw_flow (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  // Thresholds and free space in double words
  input  wire logic [`RXQW_MARK_W-1:0]   low_mark,
  input  wire logic [`RXQW_MARK_W-1:0]   high_mark,
  input  wire logic [`RXQW_MARK_W-1:0]   overrun_mark,
  input  wire logic [`RXQW_SPACE_W-1:0]  free_space,
  // Flow-control results
  output logic                           pause_q,
  output logic                           overrun_q
);
  rxqw_pkg::rxqw_flow_t state_q;
  rxqw_pkg::rxqw_flow_t state_d;

  // Hysteresis: pause at high mark, release only at or above the low mark
  always_comb begin
    state_d = state_q;
    case (state_q)
      rxqw_pkg::RXQW_FLOW_IDLE: begin
        if (free_space <= overrun_mark) begin
          state_d = rxqw_pkg::RXQW_FLOW_OVERRUN;
        end else if (free_space <= high_mark) begin
          state_d = rxqw_pkg::RXQW_FLOW_PAUSE;
        end
      end
      rxqw_pkg::RXQW_FLOW_PAUSE: begin
        if (free_space <= overrun_mark) begin
          state_d = rxqw_pkg::RXQW_FLOW_OVERRUN;
        end else if (free_space >= low_mark) begin
          state_d = rxqw_pkg::RXQW_FLOW_IDLE;
        end
      end
      rxqw_pkg::RXQW_FLOW_OVERRUN: begin
        if (free_space >= low_mark) begin
          state_d = rxqw_pkg::RXQW_FLOW_IDLE;
        end else if (free_space > overrun_mark) begin
          state_d = rxqw_pkg::RXQW_FLOW_PAUSE;
        end
      end
      default: state_d = rxqw_pkg::RXQW_FLOW_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_q <= rxqw_pkg::RXQW_FLOW_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Registered outputs follow the next state
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pause_q   <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      pause_q   <= (state_d != rxqw_pkg::RXQW_FLOW_IDLE);
      overrun_q <= (state_d == rxqw_pkg::RXQW_FLOW_OVERRUN);
    end
  end

  AST_OVERRUN_IMPLIES_PAUSE: assert property (
    @(posedge core_clk) disable iff (!rst_b) overrun_q |-> pause_q)
    else $error("overrun asserted without pause");
  AST_PAUSE_AT_HIGH: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (free_space <= high_mark) |=> pause_q)
    else $error("pause missing at high mark");
  AST_RELEASE_AT_LOW: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (free_space >= low_mark && free_space > high_mark) |=> !pause_q)
    else $error("pause held above low mark");
endmodule // rxqw_flow

// [hw/rxqw_pkg.sv]
// Types shared by the receive-queue water mark block
package rxqw_pkg;
  typedef enum logic [1:0] {
    RXQW_FLOW_IDLE    = 2'b00,
    RXQW_FLOW_PAUSE   = 2'b01,
    RXQW_FLOW_OVERRUN = 2'b10
  } rxqw_flow_t;
endpackage

// [hw/rxqw_top.sv]
// Receive-queue water mark registers, frame tally and flow-control signalling
//
// Function
// - High water mark, 12 bits RW in double words, resets to 0x400.
// - Overrun water mark, 12 bits RW in double words, resets to 0x040.
// - Frame tally in bits 15:8, refreshed on write-one to interrupt bit 13.
// - Water marks govern flow control of the receive queue only.
// - Low water mark, 12 bits RW in double words, resets to 0x600.
`timescale 1ns/1ps
`include "rxqw_cfg.svh"
module rxqw_top (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  // Host register port, 16-bit word access
  input  wire logic [`RXQW_ADDR_W-1:0]   reg_addr,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [15:0]               reg_wdata,
  output logic [15:0]                    reg_rdata_q,
  // Interrupt status acknowledge from the host write to the status register
  input  wire logic                      isr_wr,
  input  wire logic [15:0]               isr_wdata,
  // Receive queue state from the queue manager
  input  wire logic [`RXQW_TALLY_W-1:0]  rxq_frames,
  input  wire logic [`RXQW_SPACE_W-1:0]  rxq_free_space,
  // Flow control toward the MAC
  output logic                           flow_pause_q,
  output logic                           flow_overrun_q
);
  logic [`RXQW_MARK_W-1:0]  low_mark_q;
  logic [`RXQW_MARK_W-1:0]  high_mark_q;
  logic [`RXQW_MARK_W-1:0]  overrun_mark_q;
  logic [3:0]               low_rsv_q;
  logic [3:0]               high_rsv_q;
  logic [3:0]               overrun_rsv_q;
  logic [`RXQW_TALLY_W-1:0] tally_q;
  logic [7:0]               tally_low_q;
  logic                     ack_rx;
  logic                     pause_w;
  logic                     overrun_w;

  // Acknowledge of the receive interrupt snapshots the queue count
  assign ack_rx = isr_wr && isr_wdata[`RXQW_ISR_RX_BIT];

  // Water mark registers; reserved upper nibble kept as written
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      low_mark_q     <= `RXQW_LOW_RST;
      high_mark_q    <= `RXQW_HIGH_RST;
      overrun_mark_q <= `RXQW_OVERRUN_RST;
      low_rsv_q      <= 4'h0;
      high_rsv_q     <= 4'h0;
      overrun_rsv_q  <= 4'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `RXQW_OFF_LOW: begin
          low_mark_q <= reg_wdata[`RXQW_MARK_MSB:0];
          low_rsv_q  <= reg_wdata[`RXQW_RSV_MSB:`RXQW_RSV_LSB];
        end
        `RXQW_OFF_HIGH: begin
          high_mark_q <= reg_wdata[`RXQW_MARK_MSB:0];
          high_rsv_q  <= reg_wdata[`RXQW_RSV_MSB:`RXQW_RSV_LSB];
        end
        `RXQW_OFF_OVERRUN: begin
          overrun_mark_q <= reg_wdata[`RXQW_MARK_MSB:0];
          overrun_rsv_q  <= reg_wdata[`RXQW_RSV_MSB:`RXQW_RSV_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  // Tally holds between acknowledges so the host sees a stable count
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tally_q <= `RXQW_TALLY_RST;
    end else if (ack_rx) begin
      tally_q <= rxq_frames;
    end
  end

  // Low byte of the tally register is reserved but writable
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tally_low_q <= `RXQW_TALLY_LOW_RST;
    end else if (reg_wr && reg_addr == `RXQW_OFF_TALLY) begin
      tally_low_q <= reg_wdata[7:0];
    end
  end

  // Read data registered; unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `RXQW_OFF_LOW:     reg_rdata_q <= {low_rsv_q, low_mark_q};
        `RXQW_OFF_HIGH:    reg_rdata_q <= {high_rsv_q, high_mark_q};
        `RXQW_OFF_OVERRUN: reg_rdata_q <= {overrun_rsv_q, overrun_mark_q};
        `RXQW_OFF_TALLY:   reg_rdata_q <= {tally_q, tally_low_q};
        default:           reg_rdata_q <= 16'h0000;
      endcase
    end
  end

  // Threshold comparison and hysteresis for the receive queue
  rxqw_flow u_flow (
    .core_clk     (core_clk),
    .rst_b        (rst_b),
    .low_mark     (low_mark_q),
    .high_mark    (high_mark_q),
    .overrun_mark (overrun_mark_q),
    .free_space   (rxq_free_space),
    .pause_q      (pause_w),
    .overrun_q    (overrun_w)
  );

  // Retimed so top outputs come straight from flops; costs one cycle
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      flow_pause_q   <= 1'b0;
      flow_overrun_q <= 1'b0;
    end else begin
      flow_pause_q   <= pause_w;
      flow_overrun_q <= overrun_w;
    end
  end

  // Host read ordering is the host's duty; no stalling is done here

  AST_HIGH_RESET: assert property (
    @(posedge core_clk) !rst_b |=> high_mark_q == 12'h400)
    else $error("high mark reset value wrong");
  AST_OVERRUN_RESET: assert property (
    @(posedge core_clk) !rst_b |=> overrun_mark_q == 12'h040)
    else $error("overrun mark reset value wrong");
  AST_LOW_RESET: assert property (
    @(posedge core_clk) !rst_b |=> low_mark_q == 12'h600)
    else $error("low mark reset value wrong");
  AST_HIGH_WRITE_READ: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == `RXQW_OFF_HIGH) ##1 (reg_rd && !reg_wr && reg_addr == `RXQW_OFF_HIGH)
    |=> reg_rdata_q == $past(reg_wdata, 2))
    else $error("high mark readback mismatch");
  AST_OVERRUN_WRITE: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == `RXQW_OFF_OVERRUN) |=> overrun_mark_q == $past(reg_wdata[11:0]))
    else $error("overrun mark not written");
  AST_TALLY_SNAPSHOT: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    ack_rx |=> tally_q == $past(rxq_frames))
    else $error("tally not refreshed on acknowledge");
  AST_TALLY_HOLD: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !ack_rx |=> $stable(tally_q))
    else $error("tally changed without acknowledge");
  AST_UNMAPPED_ZERO: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == 11'h1B6) |=> reg_rdata_q == 16'h0000)
    else $error("reserved offset read nonzero");
  AST_FLOW_RETIME: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    pause_w |=> flow_pause_q)
    else $error("pause not forwarded");

  // Mark storage: a write lands whole, nothing else moves a mark
  AST_HIGH_WRITE: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == `RXQW_OFF_HIGH) |=> high_mark_q == $past(reg_wdata[11:0]))
    else $error("high mark not written");
  AST_LOW_WRITE: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == `RXQW_OFF_LOW) |=> low_mark_q == $past(reg_wdata[11:0]))
    else $error("low mark not written");
  AST_HIGH_HOLD: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !(reg_wr && reg_addr == `RXQW_OFF_HIGH) |=> $stable(high_mark_q))
    else $error("high mark moved without a write");
  AST_OVERRUN_HOLD: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !(reg_wr && reg_addr == `RXQW_OFF_OVERRUN) |=> $stable(overrun_mark_q))
    else $error("overrun mark moved without a write");
  AST_LOW_HOLD: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !(reg_wr && reg_addr == `RXQW_OFF_LOW) |=> $stable(low_mark_q))
    else $error("low mark moved without a write");

  // Readback shows the value held before the read edge
  AST_OVERRUN_READ: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == `RXQW_OFF_OVERRUN) |=> reg_rdata_q[11:0] == $past(overrun_mark_q))
    else $error("overrun mark readback wrong");
  AST_LOW_READ: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == `RXQW_OFF_LOW) |=> reg_rdata_q[11:0] == $past(low_mark_q))
    else $error("low mark readback wrong");
  AST_TALLY_READ: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == `RXQW_OFF_TALLY) |=> reg_rdata_q[15:8] == $past(tally_q))
    else $error("tally readback wrong");
  AST_TALLY_LOW_WRITE: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == `RXQW_OFF_TALLY) |=> tally_low_q == $past(reg_wdata[7:0]))
    else $error("tally low byte not written");
  AST_RDATA_HOLD: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !reg_rd |=> $stable(reg_rdata_q))
    else $error("read data changed without a read");

  // Reset values and retiming of the flow-control outputs
  AST_TALLY_RESET: assert property (
    @(posedge core_clk)
    !rst_b |=> tally_q == `RXQW_TALLY_RST)
    else $error("tally reset value wrong");
  AST_OUT_RESET: assert property (
    @(posedge core_clk)
    !rst_b |=> !flow_pause_q && !flow_overrun_q && reg_rdata_q == 16'h0000)
    else $error("outputs not cleared by reset");
  AST_OVERRUN_RETIME: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    overrun_w |=> flow_overrun_q)
    else $error("overrun not forwarded");
  AST_PAUSE_DROP: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !pause_w |=> !flow_pause_q)
    else $error("pause held after release");
endmodule // rxqw_top

// [sim/rxqw_host.sv]
// Host processor model driving the register port of the water mark block
`timescale 1ns/1ps
`include "rxqw_cfg.svh"
module rxqw_host (
  // Clock and read data
  input  wire logic        core_clk,
  input  wire logic [15:0] reg_rdata_q,
  // Register and status writes
  output logic [10:0]      reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [15:0]      reg_wdata,
  output logic             isr_wr,
  output logic [15:0]      isr_wdata
);
  // Idle bus shows inverted leftovers so a stale value never looks valid
  initial begin
    reg_addr  = 11'h7FF;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'hFFFF;
    isr_wr    = 1'b0;
    isr_wdata = 16'hFFFF;
  end
  // One register access; read data taken at the edge that takes the request
  task acc(input logic w, input logic [10:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge core_clk);
    #1;
    reg_wr    = w;
    reg_rd    = !w;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    q         = reg_rdata_q;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  // Status register write, one pulse
  task ack(input logic [15:0] d);
    @(posedge core_clk);
    #1;
    isr_wr    = 1'b1;
    isr_wdata = d;
    @(posedge core_clk);
    #1;
    isr_wr    = 1'b0;
    isr_wdata = ~d;
  endtask
  // Write then read the same offset on the very next edge, back to back
  task wr_rd(input logic [10:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge core_clk);
    #1;
    reg_wr    = 1'b1;
    reg_rd    = 1'b0;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b1;
    @(posedge core_clk);
    #1;
    q         = reg_rdata_q;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  // Receive service: tally read before any per-frame header read
  task svc(output logic [15:0] q);
    ack(16'h2000);
    acc(1'b0, `RXQW_OFF_TALLY, 16'h0000, q);
  endtask
endmodule // rxqw_host

// [sim/rxqw_top_bench.sv]
// Self-checking bench for the receive-queue water mark block
`timescale 1ns/1ps
`include "rxqw_cfg.svh"
module rxqw_top_bench;
  logic        core_clk, rst_b, reg_wr, reg_rd, isr_wr, flow_pause_q, flow_overrun_q;
  logic [10:0] reg_addr;
  logic [15:0] reg_wdata, isr_wdata, reg_rdata_q, q;
  logic [7:0]  rxq_frames;
  logic [11:0] rxq_free_space;
  int          n_fail = 0;
  int          n_compared = 0;

  rxqw_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .isr_wr(isr_wr),
    .isr_wdata(isr_wdata), .rxq_frames(rxq_frames), .rxq_free_space(rxq_free_space),
    .flow_pause_q(flow_pause_q), .flow_overrun_q(flow_overrun_q));
  rxqw_host u_host (.core_clk(core_clk), .reg_rdata_q(reg_rdata_q), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .isr_wr(isr_wr),
    .isr_wdata(isr_wdata));

  // Clock at 100 MHz
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task report_and_stop();
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // New free space; flow outputs follow two edges later
  task set_free(input logic [11:0] v);
    @(posedge core_clk);
    #1;
    rxq_free_space = v;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  function automatic logic [15:0] flw();
    return {14'h0, flow_pause_q, flow_overrun_q};
  endfunction
  task t_reset();
    u_host.acc(1'b0, `RXQW_OFF_HIGH, 16'h0, q);    chk({4'h0, q[11:0]}, 16'h0400);
    u_host.acc(1'b0, `RXQW_OFF_OVERRUN, 16'h0, q); chk({4'h0, q[11:0]}, 16'h0040);
    u_host.acc(1'b0, `RXQW_OFF_LOW, 16'h0, q);     chk({4'h0, q[11:0]}, 16'h0600);
    u_host.acc(1'b0, `RXQW_OFF_TALLY, 16'h0, q);   chk(q, 16'h0000);
  endtask
  // Crossings at the default marks, inclusive at each boundary
  task t_flow();
    set_free(12'h401); chk(flw(), 16'h0000);
    set_free(12'h400); chk(flw(), 16'h0002);
    set_free(12'h041); chk(flw(), 16'h0002);
    set_free(12'h040); chk(flw(), 16'h0003);
    set_free(12'h5FF); chk(flw(), 16'h0002);
    set_free(12'h600); chk(flw(), 16'h0000);
  endtask
  task t_regs();
    u_host.acc(1'b1, `RXQW_OFF_HIGH, 16'hF100, q);
    u_host.acc(1'b0, `RXQW_OFF_HIGH, 16'h0, q);    chk(q, 16'hF100);
    u_host.wr_rd(`RXQW_OFF_HIGH, 16'h3100, q);     chk(q, 16'h3100);
    u_host.acc(1'b1, `RXQW_OFF_OVERRUN, 16'hA020, q);
    u_host.acc(1'b0, `RXQW_OFF_OVERRUN, 16'h0, q); chk(q, 16'hA020);
    u_host.acc(1'b1, `RXQW_OFF_LOW, 16'h5700, q);
    u_host.acc(1'b0, `RXQW_OFF_LOW, 16'h0, q);     chk(q, 16'h5700);
    u_host.acc(1'b1, 11'h1B6, 16'hFFFF, q);
    u_host.acc(1'b0, 11'h1B6, 16'h0, q);           chk(q, 16'h0000);
    u_host.acc(1'b1, `RXQW_OFF_TALLY, 16'hFF55, q);
    u_host.acc(1'b0, `RXQW_OFF_TALLY, 16'h0, q);   chk(q, 16'h0055);
    // Programmed marks must govern the queue, not the defaults
    set_free(12'h300); chk(flw(), 16'h0000);
    set_free(12'h100); chk(flw(), 16'h0002);
    set_free(12'h020); chk(flw(), 16'h0003);
    set_free(12'h700); chk(flw(), 16'h0000);
  endtask
  // Tally moves only on a write-one to the receive status bit
  task t_tally();
    rxq_frames = 8'h05;
    u_host.ack(16'hDFFF);
    u_host.acc(1'b0, `RXQW_OFF_TALLY, 16'h0, q); chk(q, 16'h0055);
    u_host.ack(16'h2000);
    rxq_frames = 8'h09;
    u_host.acc(1'b0, `RXQW_OFF_TALLY, 16'h0, q); chk(q, 16'h0555);
    u_host.svc(q); chk(q, 16'h0955);
  endtask
  // Mid-run reset drops flow control and restores the default marks
  task t_rerst();
    set_free(12'h0F0); chk(flw(), 16'h0002);
    @(posedge core_clk);
    #1;
    rst_b = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    chk(flw(), 16'h0000);
    u_host.acc(1'b0, `RXQW_OFF_HIGH, 16'h0, q);  chk({4'h0, q[11:0]}, 16'h0400);
    u_host.acc(1'b0, `RXQW_OFF_TALLY, 16'h0, q); chk(q, 16'h0000);
    chk(flw(), 16'h0002);
  endtask
  // Watchdog far beyond the fewer than 100 cycles the tests need
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    rst_b = 1'b0;
    rxq_frames = 8'h00;
    rxq_free_space = 12'hFFF;
    repeat (10) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_flow();
    t_regs();
    t_tally();
    t_rerst();
    report_and_stop();
  end
endmodule // rxqw_top_bench
